//--- verilog/dfm_pkg.sv
// Package of constants for the drive fault monitor
package dfm_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_HZ = 1000;
	localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int unsigned LINK_LOST_S = 5;
	localparam int unsigned LINK_LOST_MS = LINK_LOST_S * TICK_HZ;
	localparam int unsigned XFER_ERR_S = 2;
	localparam int unsigned XFER_ERR_MS = XFER_ERR_S * TICK_HZ;
	localparam int unsigned OH_WIN_MIN = 5;
	localparam int unsigned OH_WIN_MS = OH_WIN_MIN * 60 * TICK_HZ;
	localparam int unsigned OH_COUNT = 3;
	// ----------------------------------------
	// Terminal function codes
	// ----------------------------------------
	localparam logic [7:0] FUNC_EXT_FAULT_A = 8'h19;
	localparam logic [7:0] FUNC_EXT_FAULT_B = 8'h44;
	localparam logic [1:0] EXT_SEL_MAX = 2'h1;
	// ----------------------------------------
	// AXI4-Lite register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MASK = 8'h04;
	localparam logic [7:0] ADDR_FAULT = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_FUNC_LO = 8'h10;
	localparam logic [7:0] ADDR_FUNC_HI = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Fault vector bit positions
	localparam int unsigned FB_LINK_LOST = 8;
	localparam int unsigned FB_XFER_ERR = 9;
	localparam int unsigned FB_BUS_CONFLICT = 10;
	localparam int unsigned FB_REPEAT_OH = 11;
	localparam int unsigned FB_EXT_OVERLOAD = 12;
	localparam int unsigned FB_FUSE_OPEN = 13;
	localparam int unsigned NFAULT = 14;
	// Control register fields
	localparam int unsigned CTRL_EXTSEL_LSB = 0;
	localparam int unsigned CTRL_FUSE_FIT = 2;
	localparam int unsigned CTRL_RESET = 3;
	localparam logic [31:0] CTRL_RST_VAL = 32'h0000_0004;
	localparam logic [31:0] MASK_RST_VAL = 32'h0000_0000;
endpackage

//--- verilog/dfm_tick.sv
// Millisecond enable pulse divider
`timescale 1ns/10ps
module dfm_tick #(
	parameter int unsigned DIV = dfm_pkg::TICK_DIV
) (
	input wire logic aclk,
	input wire logic aresetn,
	output logic tick
);
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} dfm_tick_t;
	dfm_tick_t st_r;
	dfm_tick_t st_nxt;

	// Count up one period, pulse at the wrap
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.cnt >= DIV - 1) begin
			st_nxt.cnt = 32'h0000_0000;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tick = st_r.tick;
endmodule // dfm_tick

//--- verilog/dfm_overheat.sv
// Repeated heatsink overheat detector: three events in a window
`timescale 1ns/10ps
module dfm_overheat #(
	parameter int unsigned WIN_MS = dfm_pkg::OH_WIN_MS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic overheat,
	input wire logic run_cmd,
	output logic repeat_trip
);
	typedef struct packed {
		logic [2:0][31:0] age;
		logic [2:0] live;
		logic oh_d;
		logic trip;
	} dfm_oh_t;
	dfm_oh_t st_r;
	dfm_oh_t st_nxt;
	logic rise;

	// Rising edge of the overheat fault
	assign rise = overheat & ~st_r.oh_d;

	// Slots age by tick; a new event shifts into slot 0
	always_comb begin
		st_nxt = st_r;
		st_nxt.oh_d = overheat;
		st_nxt.trip = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (tick && st_r.live[i]) begin
				if (st_r.age[i] >= WIN_MS - 1) begin
					st_nxt.live[i] = 1'b0;
				end else begin
					st_nxt.age[i] = st_r.age[i] + 32'h0000_0001;
				end
			end
		end
		if (!run_cmd) begin
			// Removing the run command forgives history
			st_nxt.live = 3'h0;
		end else if (rise) begin
			st_nxt.age[2] = st_nxt.age[1];
			st_nxt.age[1] = st_nxt.age[0];
			st_nxt.age[0] = 32'h0000_0000;
			st_nxt.live = {st_nxt.live[1:0], 1'b1};
			// Third event while two others still in window
			st_nxt.trip = st_r.live[0] & st_r.live[1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign repeat_trip = st_r.trip;
endmodule // dfm_overheat

//--- verilog/dfm_fault_monitor.sv
// Drive fault monitor top with AXI4-Lite registers
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module dfm_fault_monitor #(
	parameter int unsigned TICK_DIV = dfm_pkg::TICK_DIV,
	parameter int unsigned LOST_MS = dfm_pkg::LINK_LOST_MS,
	parameter int unsigned XERR_MS = dfm_pkg::XFER_ERR_MS,
	parameter int unsigned OH_MS = dfm_pkg::OH_WIN_MS
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] terminal_in,
	input wire logic keypad_rx_ok,
	input wire logic keypad_rx_err,
	input wire logic profibus_active,
	input wire logic modbus_active,
	input wire logic heatsink_overheat_fault,
	input wire logic run_cmd,
	input wire logic fire_mode,
	input wire logic overload_in,
	input wire logic fuse_open_in,
	output logic fault_active,
	output logic [13:0] fault_code,
	output logic irq
);
	// Width of the fault vector
	localparam int unsigned NF = dfm_pkg::NFAULT;

	// ----------------------------------------
	// State
	// ----------------------------------------
	// All state of the block, registered in one place
	typedef struct packed {
		logic [NF-1:0] latch;       // Latched faults
		logic [NF-1:0] status;      // Sticky event bits
		logic [NF-1:0] mask;        // Interrupt enables
		logic [31:0] ctrl;          // Selection, fuse fitted
		logic [7:0][7:0] func;      // Terminal functions
		logic linked;               // Keypad has exchanged data
		logic [31:0] lost_cnt;      // Ms since reset while unlinked
		logic [31:0] xerr_cnt;      // Ms of persisting errors
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic irq;
		logic awrdy; // Registered write address ready
		logic wrdy; // Registered write data ready
		logic arrdy; // Registered read address ready
		logic active; // Registered any-fault flag
	} dfm_top_t;
	dfm_top_t st_r;
	dfm_top_t st_nxt;

	logic tick;
	logic repeat_trip;
	logic [NF-1:0] cause;   // Live fault conditions
	logic [NF-1:0] event_v; // New fault this cycle
	logic [7:0] term_cause; // Live terminal fault conditions
	logic ext_en; // Terminal faults allowed by selection

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	// Millisecond enable shared by all timers
	dfm_tick #(.DIV(TICK_DIV)) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick)
	);

	// Overheat history for the repeat-trip protection
	dfm_overheat #(.WIN_MS(OH_MS)) u_oh (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick),
		.overheat(heatsink_overheat_fault),
		.run_cmd(run_cmd),
		.repeat_trip(repeat_trip)
	);

	// ----------------------------------------
	// Fault conditions
	// ----------------------------------------
	// External fault selection must be 0 or 1; higher values mute
	// every terminal fault
	assign ext_en = st_r.ctrl[dfm_pkg::CTRL_EXTSEL_LSB +: 2]
		<= dfm_pkg::EXT_SEL_MAX;

	// One terminal fault per input
	for (genvar g = 0; g < 8; g++) begin : g_term
		assign term_cause[g] = ext_en & terminal_in[g]
			& (st_r.func[g] == dfm_pkg::FUNC_EXT_FAULT_A
			| st_r.func[g] == dfm_pkg::FUNC_EXT_FAULT_B);
	end

	// Keypad and other conditions; each cause is a live level and
	// the latching happens in the next-state logic
	always_comb begin
		cause[7:0] = term_cause;
		cause[dfm_pkg::FB_LINK_LOST] = !st_r.linked
			&& st_r.lost_cnt >= LOST_MS;
		cause[dfm_pkg::FB_XFER_ERR] = st_r.linked
			&& st_r.xerr_cnt > XERR_MS;
		cause[dfm_pkg::FB_BUS_CONFLICT] = profibus_active
			& modbus_active;
		cause[dfm_pkg::FB_REPEAT_OH] = repeat_trip;
		cause[dfm_pkg::FB_EXT_OVERLOAD] = fire_mode
			& overload_in;
		cause[dfm_pkg::FB_FUSE_OPEN] = st_r.ctrl[dfm_pkg::CTRL_FUSE_FIT]
			& fuse_open_in;
	end

	// A fault counts as new only before its latch has set
	assign event_v = cause & ~st_r.latch;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		logic wr_go;
		logic rd_go;
		logic do_reset;
		wr_go = 1'b0;
		rd_go = 1'b0;
		do_reset = 1'b0;
		st_nxt = st_r;

		// Keypad link timers on millisecond ticks; both stop at their
		// limit so neither can wrap back to quiet
		if (keypad_rx_ok) begin
			st_nxt.linked = 1'b1;
		end
		if (tick && !st_r.linked && st_r.lost_cnt < LOST_MS) begin
			st_nxt.lost_cnt = st_r.lost_cnt + 32'h0000_0001;
		end
		// Any clean cycle restarts the error persistence count
		if (!keypad_rx_err) begin
			st_nxt.xerr_cnt = 32'h0000_0000;
		end else if (tick && st_r.xerr_cnt <= XERR_MS) begin
			st_nxt.xerr_cnt = st_r.xerr_cnt + 32'h0000_0001;
		end

		// Write channel: take address and data in either order; a
		// response still waiting for bready stalls the next write
		if (s_axi_awvalid && !st_r.aw_got) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_r.w_got) begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = s_axi_wdata;
			st_nxt.wstrb = s_axi_wstrb;
		end
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			wr_go = 1'b1;
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = dfm_pkg::RESP_OKAY;
			case (st_r.awaddr)
				dfm_pkg::ADDR_MASK: begin
					st_nxt.mask = st_r.wdata[NF-1:0];
				end
				dfm_pkg::ADDR_CTRL: begin
					st_nxt.ctrl = {29'h0000_0000, st_r.wdata[2:0]};
					do_reset = st_r.wdata[dfm_pkg::CTRL_RESET];
				end
				dfm_pkg::ADDR_FUNC_LO: begin
					st_nxt.func[3:0] = st_r.wdata;
				end
				dfm_pkg::ADDR_FUNC_HI: begin
					st_nxt.func[7:4] = st_r.wdata;
				end
				dfm_pkg::ADDR_STATUS, dfm_pkg::ADDR_FAULT: begin
					st_nxt.bresp = dfm_pkg::RESP_OKAY;
				end
				default: begin
					st_nxt.bresp = dfm_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// Read channel; a status read clears it, but an event in the
		// same cycle still wins below
		if (s_axi_arvalid && !st_r.rvalid) begin
			rd_go = 1'b1;
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = dfm_pkg::RESP_OKAY;
			st_nxt.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				dfm_pkg::ADDR_STATUS: begin
					st_nxt.rdata[NF-1:0] = st_r.status;
					st_nxt.status = '0;
				end
				dfm_pkg::ADDR_MASK: begin
					st_nxt.rdata[NF-1:0] = st_r.mask;
				end
				dfm_pkg::ADDR_FAULT: begin
					st_nxt.rdata[NF-1:0] = st_r.latch;
				end
				dfm_pkg::ADDR_CTRL: begin
					st_nxt.rdata = st_r.ctrl;
				end
				dfm_pkg::ADDR_FUNC_LO: begin
					st_nxt.rdata = st_r.func[3:0];
				end
				dfm_pkg::ADDR_FUNC_HI: begin
					st_nxt.rdata = st_r.func[7:4];
				end
				default: begin
					st_nxt.rresp = dfm_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end

		// Fault latches: reset frees only faults whose cause is gone,
		// so a standing fault cannot be acknowledged away
		if (do_reset) begin
			st_nxt.latch = st_r.latch & cause;
		end
		st_nxt.latch = st_nxt.latch | cause;
		// New events set sticky status, winning over a read clear
		st_nxt.status = st_nxt.status | event_v;
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);
		if (wr_go || rd_go) begin
			st_nxt.irq = |(st_nxt.status & st_nxt.mask);
		end
		// Readies and fault flag are registered from the next state
		// so that every output leaves a flip-flop directly
		st_nxt.awrdy = !st_nxt.aw_got;
		st_nxt.wrdy = !st_nxt.w_got;
		st_nxt.arrdy = !st_nxt.rvalid;
		st_nxt.active = st_nxt.latch != '0;
	end

	// Register the whole state; ctrl and the readies reset non-zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
			st_r.ctrl <= dfm_pkg::CTRL_RST_VAL;
			st_r.awrdy <= 1'b1;
			st_r.wrdy <= 1'b1;
			st_r.arrdy <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs, all from flip-flops
	// ----------------------------------------
	assign s_axi_awready = st_r.awrdy;
	assign s_axi_wready = st_r.wrdy;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = st_r.arrdy;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	// Latched faults stay on display until reset and cleared
	assign fault_code = st_r.latch;
	assign fault_active = st_r.active;
	assign irq = st_r.irq;
endmodule // dfm_fault_monitor

//--- test/dfm_keypad.sv
// Keypad link partner model for the fault monitor bench
`timescale 1ns/10ps
module dfm_keypad (
	input wire logic aclk,
	input wire logic link_en,
	input wire logic err_en,
	output logic keypad_rx_ok = 1'b0,
	output logic keypad_rx_err = 1'b0
);
	logic [2:0] cnt_r = 3'h0; // Spacing of good exchanges
	// One good exchange every eight cycles while the link is up
	always_ff @(posedge aclk) begin
		cnt_r <= cnt_r + 3'h1;
		keypad_rx_ok <= link_en && (cnt_r == 3'h7);
		keypad_rx_err <= err_en;
	end
endmodule // dfm_keypad

//--- test/dfm_chk.sv
// Assertion checker bound to the drive fault monitor top
`timescale 1ns/10ps
module dfm_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [7:0] terminal_in,
	input wire logic keypad_rx_err,
	input wire logic profibus_active,
	input wire logic modbus_active,
	input wire logic run_cmd,
	input wire logic fire_mode,
	input wire logic overload_in,
	input wire logic fuse_open_in,
	input wire logic fault_active,
	input wire logic [13:0] fault_code
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Summary flag tracks the latched vector
	property p_any;
		fault_active == (|fault_code);
	endproperty
	a_any: assert property (p_any) else $error("fault flag wrong");
	// Terminal fault needs its terminal high
	property p_term;
		$rose(fault_code[0]) |-> $past(terminal_in[0]);
	endproperty
	a_term: assert property (p_term) else $error("terminal fault");
	// The error level two edges back fed the persistence count
	property p_xerr;
		$rose(fault_code[9]) |-> $past(keypad_rx_err, 2);
	endproperty
	a_xerr: assert property (p_xerr) else $error("transfer fault");
	property p_conf;
		profibus_active && modbus_active |=> fault_code[10];
	endproperty
	a_conf: assert property (p_conf) else $error("bus conflict");
	// A latch only drops once its cause is gone
	property p_hold;
		$fell(fault_code[10]) |-> !$past(profibus_active && modbus_active);
	endproperty
	a_hold: assert property (p_hold) else $error("latch lost");
	// The trip is registered once before it latches
	property p_oh;
		$rose(fault_code[11]) |-> $past(run_cmd, 2);
	endproperty
	a_oh: assert property (p_oh) else $error("overheat trip");
	property p_ovl;
		fire_mode && overload_in |=> fault_code[12];
	endproperty
	a_ovl: assert property (p_ovl) else $error("overload missed");
	property p_ovln;
		$rose(fault_code[12]) |-> $past(fire_mode);
	endproperty
	a_ovln: assert property (p_ovln) else $error("overload out");
	// Fitting is a control bit the checker cannot see, so only the
	// step from a fuse fault back to an open fuse is checked
	property p_fuse;
		$rose(fault_code[13]) |-> $past(fuse_open_in);
	endproperty
	a_fuse: assert property (p_fuse) else $error("fuse fault unasked");
	property p_rd;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_rd: assert property (p_rd) else $error("read overlap");
	c_lost: cover property ($rose(fault_code[8]));
	c_oh: cover property ($rose(fault_code[11]));
	c_term: cover property ($rose(fault_code[0]));
endmodule // dfm_chk

bind dfm_fault_monitor dfm_chk u_chk (.aclk, .aresetn, .s_axi_arready,
	.s_axi_rvalid, .terminal_in, .keypad_rx_err, .profibus_active,
	.modbus_active, .run_cmd, .fire_mode, .overload_in, .fuse_open_in,
	.fault_active, .fault_code);

//--- test/dfm_fault_monitor_tb_top.sv
// Self-checking bench for the drive fault monitor
`timescale 1ns/10ps
module dfm_fault_monitor_tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [7:0] terminal_in = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic profibus_active = 1'b0, modbus_active = 1'b0, run_cmd = 1'b0;
	logic heatsink_overheat_fault = 1'b0, fire_mode = 1'b0;
	logic overload_in = 1'b0, fuse_open_in = 1'b0, lnk = 1'b0, err = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, fault_active, irq, keypad_rx_ok, keypad_rx_err;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, fcw;
	logic [13:0] fault_code;
	int fail_count = 0;
	int compares = 0;
	assign fcw = {18'h0_0000, fault_code};
	always #12.5 aclk = ~aclk;
	dfm_fault_monitor #(.TICK_DIV(4), .LOST_MS(5), .XERR_MS(2), .OH_MS(50))
	DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .terminal_in, .keypad_rx_ok,
		.keypad_rx_err, .profibus_active, .modbus_active,
		.heatsink_overheat_fault, .run_cmd, .fire_mode, .overload_in,
		.fuse_open_in, .fault_active, .fault_code, .irq);
	dfm_keypad u_kp (.aclk, .link_en(lnk), .err_en(err), .keypad_rx_ok,
		.keypad_rx_err);
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
			fail_count++;
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Write cycle: both halves offered, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'({1'b1, er}), 32'({s_axi_bvalid, s_axi_bresp}));
	endtask
	// Read cycle with expected data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rresp", 32'({1'b1, er}), 32'({s_axi_rvalid, s_axi_rresp}));
		chk("rdata", e, s_axi_rdata);
	endtask
	task automatic frst;
		wr(dfm_pkg::ADDR_CTRL, 32'h0000_000C, dfm_pkg::RESP_OKAY);
		wt(2);
	endtask
	task automatic heat;
		heatsink_overheat_fault <= 1'b1;
		wt(2);
		heatsink_overheat_fault <= 1'b0;
		wt(8);
	endtask
	task automatic stop_test;
		$display("mismatches %0d compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		wt(6);
		aresetn <= 1'b1;
		wt(8);
		chk("early", 32'h0000_0000, fcw);
		rd(dfm_pkg::ADDR_MASK, 32'h0000_0000, dfm_pkg::RESP_OKAY);
		rd(dfm_pkg::ADDR_CTRL, 32'h0000_0004, dfm_pkg::RESP_OKAY);
		wt(30);
		chk("lost", 32'h0000_0100, fcw);
		chk("irq masked", 32'h0000_0000, 32'(irq));
		wr(dfm_pkg::ADDR_MASK, 32'h0000_3FFF, dfm_pkg::RESP_OKAY);
		wt(2);
		chk("irq", 32'h0000_0001, 32'(irq));
		rd(dfm_pkg::ADDR_STATUS, 32'h0000_0100, dfm_pkg::RESP_OKAY);
		wt(2);
		chk("irq clear", 32'h0000_0000, 32'(irq));
		lnk <= 1'b1;
		wt(20);
		frst();
		chk("relink", 32'h0000_0000, fcw);
		err <= 1'b1;
		wt(4);
		err <= 1'b0;
		wt(12);
		chk("short err", 32'h0000_0000, fcw);
		err <= 1'b1;
		wt(20);
		chk("long err", 32'h0000_0200, fcw);
		err <= 1'b0;
		frst();
		wr(dfm_pkg::ADDR_FUNC_LO, 32'h0000_4419, dfm_pkg::RESP_OKAY);
		wr(dfm_pkg::ADDR_FUNC_HI, 32'h1900_0000, dfm_pkg::RESP_OKAY);
		terminal_in <= 8'hFF;
		for (int s = 0; s < 4; s++) begin
			wr(dfm_pkg::ADDR_CTRL, 32'(s) + 32'h0000_0004, 2'h0);
			wr(dfm_pkg::ADDR_CTRL, 32'(s) + 32'h0000_000C, 2'h0);
			wt(3);
			chk("term", s < 2 ? 32'h83 : 32'h0, fcw);
		end
		terminal_in <= 8'h00;
		frst();
		profibus_active <= 1'b1;
		wt(3);
		chk("one bus", 32'h0000_0000, fcw);
		modbus_active <= 1'b1;
		wt(2);
		profibus_active <= 1'b0;
		modbus_active <= 1'b0;
		overload_in <= 1'b1;
		wt(3);
		chk("conflict", 32'h0000_0400, fcw);
		fire_mode <= 1'b1;
		fuse_open_in <= 1'b1;
		wt(3);
		overload_in <= 1'b0;
		fire_mode <= 1'b0;
		fuse_open_in <= 1'b0;
		rd(dfm_pkg::ADDR_FAULT, 32'h3400, 2'h0);
		frst();
		chk("cleared", 32'h0000_0000, fcw);
		// No fuse fitted: an open fuse reading is ignored
		wr(dfm_pkg::ADDR_CTRL, 32'h0000_0000, dfm_pkg::RESP_OKAY);
		fuse_open_in <= 1'b1;
		wt(3);
		chk("unfitted", 32'h0000_0000, fcw);
		fuse_open_in <= 1'b0;
		frst();
		// Dropping the run command forgives earlier overheats
		run_cmd <= 1'b1;
		heat();
		run_cmd <= 1'b0;
		wt(2);
		run_cmd <= 1'b1;
		heat();
		heat();
		chk("two heat", 32'h0000_0000, fcw);
		heat();
		chk("three heat", 32'h0000_0800, fcw);
		chk("active", 32'h0000_0001, 32'(fault_active));
		run_cmd <= 1'b0;
		rd(8'h20, 32'h0000_0000, dfm_pkg::RESP_SLVERR);
		wr(8'h20, 32'h0000_0000, dfm_pkg::RESP_SLVERR);
		stop_test();
	end
	// Watchdog against a hung handshake
	initial begin
		wt(3000);
		fail_count++;
		stop_test();
	end
endmodule // dfm_fault_monitor_tb_top
